// file: pkg/gate_pkg.sv
package gate_pkg;

  // Clock and sampling
  localparam int CLK_PERIOD_NS      = 8;
  localparam int SAMPLE_RATE_HZ     = 50000;
  localparam int SAMPLE_PERIOD_NS   = 1000000000 / SAMPLE_RATE_HZ;
  localparam int SAMPLE_CYCLES      = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W             = 12;

  // Fault timing, counted in sample periods (rounded down: maximum times)
  localparam int FAULT_ENTRY_US     = 100;
  localparam int SAMPLE_PERIOD_US   = SAMPLE_PERIOD_NS / 1000;
  localparam int RECOVER_BASE_TICKS = FAULT_ENTRY_US / SAMPLE_PERIOD_US;

  // Data path widths and averaging history
  localparam int DISP_W             = 16;
  localparam int INT_W              = 16;
  localparam int HOLD_W             = 16;
  localparam int HIST_LOG2          = 11;
  localparam int HIST_DEPTH         = 2048;
  localparam int AVG_LOG2_MAX       = 17;
  localparam int BLK_W              = 6;
  localparam int ENTRY_W            = DISP_W + BLK_W;
  localparam int SUM_W              = ENTRY_W + HIST_LOG2;
  localparam int REC_W              = 18;
  localparam int FIFO_DEPTH         = 16;
  localparam int PROG_COUNT         = 8;
  localparam int PROG_W             = 3;

  // Default settings
  localparam logic [4:0]        DEFAULT_AVG_LOG2  = 5'h0B;
  localparam logic signed [15:0] DEFAULT_LOW_LIMIT  = 16'h0032;
  localparam logic signed [15:0] DEFAULT_HIGH_LIMIT = 16'h02EE;
  localparam logic [15:0]       DEFAULT_HOLD      = 16'h0000;

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_ALT    = 1'b1
  } meas_mode_type;

  typedef struct packed {
    logic [4:0]         avg_log2;
    meas_mode_type      mode;
    logic               auto_zero;
    logic               filter_on;
    logic signed [15:0] low_limit;
    logic signed [15:0] high_limit;
    logic [15:0]        low_hold;
    logic [15:0]        high_hold;
  } settings_type;

  localparam settings_type DEFAULT_SETTINGS = '{
    avg_log2:   DEFAULT_AVG_LOG2,
    mode:       MODE_NORMAL,
    auto_zero:  1'b0,
    filter_on:  1'b0,
    low_limit:  DEFAULT_LOW_LIMIT,
    high_limit: DEFAULT_HIGH_LIMIT,
    low_hold:   DEFAULT_HOLD,
    high_hold:  DEFAULT_HOLD
  };

  typedef struct packed {
    logic               ok;
    logic signed [15:0] value;
  } disp_word_type;

  typedef enum logic [1:0] {
    GATE_OK      = 2'b00,
    GATE_HOLD    = 2'b01,
    GATE_FAULT   = 2'b11,
    GATE_RECOVER = 2'b10
  } gate_state_type;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync import gate_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1;

  // Multi-bit buses rely on the sensor holding data steady around sampling
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage1  <= '0;
      pin_out <= '0;
    end else begin
      stage1  <= pin_in;
      pin_out <= stage1;
    end
  end

endmodule

// file: rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo import gate_pkg::*; #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      used;
  logic [AW:0]      next_used;
  logic             push;
  logic             pop;

  assign push = in_valid && in_ready;
  assign pop  = (used != '0) && (!out_valid || out_ready);

  always_comb begin
    next_used = used + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      used      <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      used     <= next_used;
      in_ready <= (next_used != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
        rd_ptr    <= rd_ptr + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/averaging_intensity_gate.sv
// What this block does
// - Sample displacement at fifty thousand per second
// - Counts 1..2048: moving average, update every sample
// - Counts 4096..131072: advance by count/2048 samples
// - Enter low-light fault within 100 us
// - Recover within 100 us plus 20 us per count
// - Over-light fault uses same entry, recovery timing
// - Nonzero hold suppresses fault, keeps last good value
// - Separate hold durations for low and over light
// - Low-light ending inside hold: resume within 100 us
// - Over-light ending inside hold: same short recovery
// - Defaults: count 2048, normal, auto-zero off, filter off
// - Initialization restores defaults, erases stored programs
// - Output MSB low on light fault, or on error outside a hold
// - Counts up to 2048 give output every 20 us
`timescale 1ns/1ps
module averaging_intensity_gate import gate_pkg::*; (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [DISP_W-1:0]   sensor_disp,
  input  wire logic [INT_W-1:0]    sensor_intensity,
  input  wire logic                sensor_error,
  input  wire settings_type        cfg_in,
  input  wire logic                cfg_write,
  input  wire logic [PROG_W-1:0]   prog_sel,
  input  wire logic                prog_save,
  input  wire logic                prog_load,
  input  wire logic                init_request,
  output disp_word_type            out_word,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic                     fifo_ready,
  output logic                     overrun,
  output logic                     low_light_fault,
  output logic                     over_light_fault,
  output settings_type             settings_active
);

  // Settings and stored programs
  settings_type              settings;
  settings_type              prog_mem [PROG_COUNT];
  logic                      settings_changed;
  logic [4:0]                eff_log2;

  // Synchronised sensor pins
  logic [DISP_W+INT_W:0]     pins_sync;
  logic signed [DISP_W-1:0]  samp_disp;
  logic signed [INT_W-1:0]   samp_int;
  logic                      samp_err;

  // Sample clocking
  logic [TICK_W-1:0]         tick_cnt;
  logic                      sample_tick;

  // Averaging path
  logic [HIST_LOG2:0]        win_len;
  logic [BLK_W-1:0]          blk_last;
  logic signed [ENTRY_W-1:0] hist [HIST_DEPTH];
  logic signed [ENTRY_W-1:0] block_acc;
  logic [BLK_W-1:0]          block_cnt;
  logic signed [ENTRY_W-1:0] entry;
  logic signed [ENTRY_W-1:0] old_entry;
  logic                      entry_go;
  logic                      stage_b;
  logic                      avg_go;
  logic [HIST_LOG2:0]        fill;
  logic [HIST_LOG2-1:0]      wr_ptr;
  logic [HIST_LOG2-1:0]      rd_addr;
  logic signed [SUM_W-1:0]   sum;
  logic signed [SUM_W-1:0]   sub_term;
  logic signed [DISP_W-1:0]  avg_value;

  // Intensity gates, channel 0 low light, channel 1 over light
  logic [1:0]                cond;
  logic [1:0]                gate_hold;
  logic [1:0]                gate_fault;
  logic [HOLD_W-1:0]         hold_lim [2];
  logic [REC_W-1:0]          rec_last;

  // Output staging
  disp_word_type             push_word;
  logic                      push_valid;
  logic                      push_ready;
  logic signed [DISP_W-1:0]  last_good;

  // Settings bank
  always_ff @(posedge core_clk) begin
    settings_changed <= 1'b0;
    if (!resetn || init_request) begin
      settings         <= DEFAULT_SETTINGS;
      settings_changed <= 1'b1;
    end else if (cfg_write) begin
      settings         <= cfg_in;
      settings_changed <= 1'b1;
    end else if (prog_load) begin
      settings         <= prog_mem[prog_sel];
      settings_changed <= 1'b1;
    end
  end

  generate
    for (genvar p = 0; p < PROG_COUNT; p++) begin : g_prog
      always_ff @(posedge core_clk) begin
        if (!resetn || init_request) begin
          prog_mem[p] <= DEFAULT_SETTINGS;
        end else if (prog_save && prog_sel == PROG_W'(p)) begin
          prog_mem[p] <= settings;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      settings_active <= DEFAULT_SETTINGS;
    end else begin
      settings_active <= settings;
    end
  end

  // Counts beyond 131072 (AVG_LOG2_MAX) are clamped to the largest supported
  always_comb begin
    eff_log2 = settings.avg_log2;
    if (settings.avg_log2 > 5'(AVG_LOG2_MAX)) begin
      eff_log2 = 5'(AVG_LOG2_MAX);
    end
  end

  always_comb begin
    if (eff_log2 <= 5'(HIST_LOG2)) begin
      win_len  = (HIST_LOG2+1)'(1 << eff_log2);
      blk_last = '0;
    end else begin
      win_len  = (HIST_LOG2+1)'(HIST_DEPTH);
      blk_last = BLK_W'((1 << (eff_log2 - 5'(HIST_LOG2))) - 1);
    end
  end

  pin_sync #(
    .WIDTH (DISP_W + INT_W + 1)
  ) u_pin_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_in   ({sensor_error, sensor_intensity, sensor_disp}),
    .pin_out  (pins_sync)
  );

  assign samp_disp = pins_sync[DISP_W-1:0];
  assign samp_int  = pins_sync[DISP_W+INT_W-1:DISP_W];
  assign samp_err  = pins_sync[DISP_W+INT_W];

  // Fixed-rate sample strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tick_cnt    <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (tick_cnt == TICK_W'(SAMPLE_CYCLES - 1)) begin
        tick_cnt    <= '0;
        sample_tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  // History holds one sample or one block sum per entry
  assign rd_addr  = wr_ptr - win_len[HIST_LOG2-1:0];
  assign sub_term = (fill == win_len) ? SUM_W'(old_entry) : '0;

  always_ff @(posedge core_clk) begin
    if (entry_go) begin
      old_entry <= hist[rd_addr];
    end
    if (stage_b) begin
      hist[wr_ptr] <= entry;
    end
  end

  // A settings change restarts the window rather than mixing lengths
  always_ff @(posedge core_clk) begin
    if (!resetn || settings_changed) begin
      block_acc <= '0;
      block_cnt <= '0;
      entry     <= '0;
      entry_go  <= 1'b0;
      stage_b   <= 1'b0;
      avg_go    <= 1'b0;
      fill      <= '0;
      wr_ptr    <= '0;
      sum       <= '0;
    end else begin
      entry_go <= 1'b0;
      stage_b  <= entry_go;
      avg_go   <= stage_b;
      if (sample_tick) begin
        if (block_cnt == blk_last) begin
          entry     <= block_acc + ENTRY_W'(samp_disp);
          block_acc <= '0;
          block_cnt <= '0;
          entry_go  <= 1'b1;
        end else begin
          block_acc <= block_acc + ENTRY_W'(samp_disp);
          block_cnt <= block_cnt + 1'b1;
        end
      end
      if (stage_b) begin
        sum    <= sum + SUM_W'(entry) - sub_term;
        wr_ptr <= wr_ptr + 1'b1;
        if (fill != win_len) begin
          fill <= fill + 1'b1;
        end
      end
    end
  end

  // Until the window fills the average reads low
  assign avg_value = DISP_W'(sum >>> eff_log2);

  // Intensity gates
  assign cond[0]     = samp_int < settings.low_limit;
  assign cond[1]     = samp_int > settings.high_limit;
  assign hold_lim[0] = settings.low_hold;
  assign hold_lim[1] = settings.high_hold;
  // Two ticks are given back, for the detection delay of the sample grid and the tick that leaves GATE_FAULT
  assign rec_last    = REC_W'(RECOVER_BASE_TICKS - 2) +
                       REC_W'(1 << eff_log2);

  generate
    for (genvar c = 0; c < 2; c++) begin : g_gate
      gate_state_type    state;
      logic [HOLD_W-1:0] hold_cnt;
      logic [REC_W-1:0]  rec_cnt;

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          state    <= GATE_OK;
          hold_cnt <= '0;
          rec_cnt  <= '0;
        end else if (sample_tick) begin
          unique case (state)
            GATE_OK: begin
              hold_cnt <= '0;
              if (cond[c]) begin
                if (hold_lim[c] == '0) begin
                  state <= GATE_FAULT;
                end else begin
                  state <= GATE_HOLD;
                end
              end
            end
            GATE_HOLD: begin
              if (!cond[c]) begin
                state <= GATE_OK;
              end else if (hold_cnt + 1'b1 >= hold_lim[c]) begin
                state <= GATE_FAULT;
              end else begin
                hold_cnt <= hold_cnt + 1'b1;
              end
            end
            GATE_FAULT: begin
              rec_cnt <= '0;
              if (!cond[c]) begin
                state <= GATE_RECOVER;
              end
            end
            GATE_RECOVER: begin
              if (cond[c]) begin
                state <= GATE_FAULT;
              end else if (rec_cnt >= rec_last) begin
                state <= GATE_OK;
              end else begin
                rec_cnt <= rec_cnt + 1'b1;
              end
            end
          endcase
        end
      end

      assign gate_hold[c]  = (state == GATE_HOLD);
      assign gate_fault[c] = (state == GATE_FAULT) ||
                             (state == GATE_RECOVER);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      low_light_fault  <= 1'b0;
      over_light_fault <= 1'b0;
    end else begin
      low_light_fault  <= gate_fault[0];
      over_light_fault <= gate_fault[1];
    end
  end

  // Output staging: every average, or every block in the long range
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      push_valid <= 1'b0;
      push_word  <= '0;
      last_good  <= '0;
    end else begin
      push_valid <= avg_go;
      if (avg_go) begin
        if (gate_fault != 2'b00) begin
          push_word <= '{ok: 1'b0, value: last_good};
        end else if (gate_hold != 2'b00) begin
          push_word <= '{ok: 1'b1, value: last_good};
        end else if (samp_err) begin
          push_word <= '{ok: 1'b0, value: avg_value};
        end else begin
          push_word <= '{ok: 1'b1, value: avg_value};
          last_good <= avg_value;
        end
      end
    end
  end

  // The sample grid cannot stall, so a full buffer drops and flags it
  // A drop in the same cycle as a clear wins, so no loss goes unseen
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      overrun <= 1'b0;
    end else if (push_valid && !push_ready) begin
      overrun <= 1'b1;
    end else if (init_request) begin
      overrun <= 1'b0;
    end
  end

  assign fifo_ready = push_ready;

  word_fifo #(
    .WIDTH ($bits(disp_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_word_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_word)
  );

endmodule

// file: tb/gate_monitor.sv
`timescale 1ns/1ps
module gate_monitor import gate_pkg::*; (
  input wire logic              core_clk,
  input wire logic              resetn,
  input wire logic [DISP_W-1:0] sensor_disp,
  input wire logic [INT_W-1:0]  sensor_intensity,
  input wire logic              sensor_error,
  input wire settings_type      cfg_in,
  input wire logic              cfg_write,
  input wire logic [PROG_W-1:0] prog_sel,
  input wire logic              prog_save,
  input wire logic              prog_load,
  input wire logic              init_request,
  input wire disp_word_type     out_word,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic              fifo_ready,
  input wire logic              overrun,
  input wire logic              low_light_fault,
  input wire logic              over_light_fault,
  input wire settings_type      settings_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic lo_in;
  logic hi_in;
  int   lo_cnt;
  int   hi_cnt;
  int   ok_cnt;
  int   lo_max;
  int   hi_max;
  int   rec_max;
  // Counted at the pins, so limits carry sync and compare slack
  assign lo_in   = $signed(sensor_intensity) < settings_active.low_limit;
  assign hi_in   = $signed(sensor_intensity) > settings_active.high_limit;
  assign lo_max  = (int'(settings_active.low_hold) + 1) * SAMPLE_CYCLES
                   + 10;
  assign hi_max  = (int'(settings_active.high_hold) + 1) * SAMPLE_CYCLES
                   + 10;
  assign rec_max = ((1 << settings_active.avg_log2) + 5) * SAMPLE_CYCLES
                   + 10;
  always_ff @(posedge core_clk) begin
    lo_cnt <= (!resetn || !lo_in) ? 0 : lo_cnt + int'(lo_cnt < lo_max);
    hi_cnt <= (!resetn || !hi_in) ? 0 : hi_cnt + int'(hi_cnt < hi_max);
    ok_cnt <= (!resetn || lo_in || hi_in) ? 0
              : ok_cnt + int'(ok_cnt < rec_max);
  end
  sequence s_cfg_take;
    cfg_write && !init_request && cfg_in.avg_log2 <= 5'h11;
  endsequence
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  a_reset_clean: assert property (
    $rose(resetn) |-> settings_active == DEFAULT_SETTINGS && !out_valid
      && !overrun && !low_light_fault && !over_light_fault)
    else $error("outputs not clean after reset");
  a_init_defaults: assert property (
    init_request |-> ##2 settings_active == DEFAULT_SETTINGS)
    else $error("init did not restore defaults");
  a_cfg_copy: assert property (
    s_cfg_take |-> ##2 settings_active == $past(cfg_in, 2))
    else $error("settings write not applied");
  a_low_entry: assert property (
    lo_cnt == lo_max |-> low_light_fault)
    else $error("low light fault late");
  a_high_entry: assert property (
    hi_cnt == hi_max |-> over_light_fault)
    else $error("over light fault late");
  a_light_recover: assert property (
    ok_cnt == rec_max |-> !low_light_fault && !over_light_fault)
    else $error("fault recovery late");
  a_hold_low_first: assert property (
    $rose(low_light_fault) |->
      lo_cnt + SAMPLE_CYCLES >=
        int'(settings_active.low_hold) * SAMPLE_CYCLES)
    else $error("low flag before hold expired");
  a_hold_high_first: assert property (
    $rose(over_light_fault) |->
      hi_cnt + SAMPLE_CYCLES >=
        int'(settings_active.high_hold) * SAMPLE_CYCLES)
    else $error("over flag before hold expired");
  a_stall_hold: assert property (
    s_stall |=> out_valid && $stable(out_word))
    else $error("word changed while stalled");
  a_overrun_stick: assert property (
    $fell(overrun) |->
      $past(init_request) || $past(init_request, 2) || $past(init_request, 3))
    else $error("overrun cleared without init");
endmodule
bind averaging_intensity_gate gate_monitor u_gate_monitor (.*);

// file: tb/sensor_head_model.sv
`timescale 1ns/1ps
module sensor_head_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] cmd_disp,
  input  wire logic [15:0] cmd_int,
  input  wire logic        cmd_err,
  output logic      [15:0] sensor_disp,
  output logic      [15:0] sensor_intensity,
  output logic             sensor_error
);
  initial begin
    sensor_disp = 16'h0000;
    sensor_intensity = 16'h0000;
    sensor_error = 1'b0;
  end
  // Head has its own timebase, so changes land between core edges
  always @(posedge core_clk) begin
    sensor_disp      <= #3 cmd_disp;
    sensor_intensity <= #3 cmd_int;
    sensor_error     <= #3 cmd_err;
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %0t got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top import gate_pkg::*; ();
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] disp;
    logic        err;
    logic [15:0] hold;
    logic [3:0]  ticks;
    logic        ok;
    logic [15:0] value;
    logic        check_value;
    logic [1:0]  flags;
  } row_type;
  // Count 1 keeps recovery to a few ticks; flags are {low, over}
  row_type rows [9] = '{
    '{16'h0064, 16'h0123, 1'b0, 16'h0000, 4'h2, 1'b1, 16'h0123, 1'b1, 2'h0},
    '{16'h000a, 16'h0123, 1'b0, 16'h0000, 4'h2, 1'b0, 16'h0123, 1'b1, 2'h2},
    '{16'h0064, 16'h0456, 1'b0, 16'h0000, 4'h7, 1'b1, 16'h0456, 1'b1, 2'h0},
    '{16'h0320, 16'h0456, 1'b0, 16'h0000, 4'h2, 1'b0, 16'h0456, 1'b1, 2'h1},
    '{16'h0064, 16'h0456, 1'b1, 16'h0000, 4'h7, 1'b0, 16'h0000, 1'b0, 2'h0},
    '{16'h0064, 16'h0789, 1'b0, 16'h0003, 4'h2, 1'b1, 16'h0789, 1'b1, 2'h0},
    '{16'h000a, 16'h0abc, 1'b0, 16'h0003, 4'h1, 1'b1, 16'h0789, 1'b1, 2'h0},
    '{16'h0064, 16'h0abc, 1'b0, 16'h0003, 4'h2, 1'b1, 16'h0abc, 1'b1, 2'h0},
    '{16'h0320, 16'h0abc, 1'b0, 16'h0003, 4'h2, 1'b0, 16'h0abc, 1'b1, 2'h1}
  };
  logic          core_clk;
  logic          resetn;
  logic          cfg_write;
  logic          prog_save;
  logic          prog_load;
  logic          init_request;
  logic          out_ready;
  logic          cmd_err;
  logic          sensor_error;
  logic          out_valid;
  logic          fifo_ready;
  logic          overrun;
  logic          low_light_fault;
  logic          over_light_fault;
  logic [2:0]    prog_sel;
  logic [15:0]   cmd_disp;
  logic [15:0]   cmd_int;
  logic [15:0]   sensor_disp;
  logic [15:0]   sensor_intensity;
  settings_type  cfg_in;
  settings_type  settings_active;
  disp_word_type out_word;
  disp_word_type last_word;
  int            miscompares;
  int            total_checks;
  int            words;
  int            start_words;
  sensor_head_model u_sensor_head_model (.*);
  averaging_intensity_gate u_averaging_intensity_gate (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (out_valid && out_ready) begin
      last_word <= out_word;
      words <= words + 1;
    end
  end
  task automatic ticks(input int n);
    repeat (n * SAMPLE_CYCLES) @(posedge core_clk);
  endtask
  // Bits: init, load, save, write; settings settle two edges later
  task automatic pulse(input logic [3:0] p);
    @(posedge core_clk);
    {init_request, prog_load, prog_save, cfg_write} <= p;
    @(posedge core_clk);
    {init_request, prog_load, prog_save, cfg_write} <= 4'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (120000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    {init_request, prog_load, prog_save, cfg_write} = 4'h0;
    out_ready = 1'b1;
    prog_sel = 3'h5;
    cmd_int = 16'h0064;
    cmd_disp = 16'h0000;
    cmd_err = 1'b0;
    cfg_in = DEFAULT_SETTINGS;
    cfg_in.avg_log2 = 5'h00;
    words = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    pulse(4'h1);
    foreach (rows[k]) begin
      if (rows[k].hold !== cfg_in.low_hold) begin
        cfg_in.low_hold <= rows[k].hold;
        pulse(4'h1);
      end
      cmd_int <= rows[k].level;
      cmd_disp <= rows[k].disp;
      cmd_err <= rows[k].err;
      ticks(int'(rows[k].ticks));
      `CHECK(last_word.ok, rows[k].ok)
      if (rows[k].check_value)
        `CHECK(last_word.value, rows[k].value)
      `CHECK({low_light_fault, over_light_fault}, rows[k].flags)
      $display("row %0d done", k);
    end
    // Far side stalls until the buffer refuses, then drains it
    cmd_int <= 16'h0064;
    out_ready <= 1'b0;
    ticks(19);
    `CHECK(overrun, 1'b1)
    `CHECK(fifo_ready, 1'b0)
    start_words = words;
    out_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    `CHECK(words - start_words >= 16, 1'b1)
    `CHECK(fifo_ready, 1'b1)
    $display("overrun test done");
    pulse(4'h2);
    pulse(4'h8);
    `CHECK(overrun, 1'b0)
    `CHECK(settings_active, DEFAULT_SETTINGS)
    pulse(4'h4);
    `CHECK(settings_active, DEFAULT_SETTINGS)
    $display("init test done");
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHECK({out_valid, overrun, low_light_fault, over_light_fault}, 4'h0)
    `CHECK(fifo_ready, 1'b1)
    `CHECK(settings_active, DEFAULT_SETTINGS)
    $display("reset test done");
    stop_test();
  end
endmodule
